// ===== design/ccvd_debounce_config.sv
// ccvd_debounce_config: settle period and threshold filter mask
// registers, strap-dependent defaults, and the cc, supply and cable
// power debouncers they steer.
// assumes the register port and the threshold inputs are on clk_sys;
// strap pins are asynchronous and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - pd settle period register, 1 ms, reset 0x0A
// - cable fault period register, reset 0x02
// - per-pin cc masks select filtered thresholds
// - newly set cc bits restart on mismatch
// - clearing mask bits alone raises no restart request, but a cleared bit whose raw level is high restarts the count
// - one cc debouncer, any filtered change on either pin restarts it
// - cc mask writes apply at scan end
// - cc mask defaults follow straps
// - unfiltered cc threshold result follows immediately
// - supply mask selects filtered supply thresholds
// - newly set supply bits restart on mismatch
// - supply mask layout, reserved bits read zero
// - unfiltered supply result follows immediately
// - supply mask defaults follow configuration pin
module ccvd_debounce_config
  import ccvd_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_UNIT_CYCLES
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   reg_rd_valid,
  input  wire logic [1:0]        role_config_pin,
  input  wire logic              power_level_pin0,
  input  wire logic              power_level_pin1,
  input  wire logic              cc_scan_end,
  input  wire logic [7:0]        cc1_threshold_raw,
  input  wire logic [7:0]        cc2_threshold_raw,
  input  wire logic [7:0]        supply_threshold_raw,
  input  wire logic              cable_overload_raw,
  input  wire logic              cc_backdrive_raw,
  output logic      [7:0]        cc1_threshold_result,
  output logic      [7:0]        cc2_threshold_result,
  output logic      [7:0]        supply_threshold_result,
  output logic                   cable_overload_settled,
  output logic                   cc_backdrive_settled,
  output logic                   strap_done
);

  // ---- register file state ----
  logic [7:0]     pd_settle_period_q;          // cc settle period
  logic [7:0]     vconn_fault_settle_period_q; // cable fault period
  logic [7:0]     cc1_mask_pend_q;             // cc1 mask as written
  logic [7:0]     cc2_mask_pend_q;             // cc2 mask as written
  logic [7:0]     cc1_mask_act_q;              // cc1 mask in use
  logic [7:0]     cc2_mask_act_q;              // cc2 mask in use
  logic [7:0]     vbus_mask_q;                 // supply mask in use
  logic [7:0]     rdata_q;                     // read data register
  logic           rd_valid_q;                  // read answer strobe

  // ---- restart requests, raised in the same cycle a mask takes effect ----
  logic           cc_restart_q;    // cc debouncer restart
  logic           vbus_restart_q;  // supply debouncer restart

  // ---- previous raw vectors for the mask mismatch check ----
  logic [7:0]     cc1_raw_prev_q;  // cc1 raw last cycle
  logic [7:0]     cc2_raw_prev_q;  // cc2 raw last cycle
  logic [7:0]     vbus_raw_prev_q; // supply raw last cycle

  // ---- strap capture ----
  logic [3:0]     strap_s1_q;      // first synchroniser stage
  logic [3:0]     strap_s2_q;      // second stage
  logic [3:0]     strap_s3_q;      // third stage
  logic [1:0]     strap_cnt_q;     // cycles spent waiting
  ccvd_state_type state_q;         // strap or run
  ccvd_state_type state_d;         // next state

  // ---- shared time base ----
  logic           tick_ms;         // one pulse per ms

  // ---- address decode ----
  wire hit_pd_w    = (reg_addr == PD_SETTLE_OFS);     // pd period
  wire hit_vconn_w = (reg_addr == VCONN_SETTLE_OFS);  // cable period
  wire hit_cc1_w   = (reg_addr == CC1_MASK_OFS);      // cc1 mask
  wire hit_cc2_w   = (reg_addr == CC2_MASK_OFS);      // cc2 mask
  wire hit_vbus_w  = (reg_addr == VBUS_MASK_OFS);     // supply mask

  // write strobes per register
  wire wr_pd_w     = reg_wr_en & hit_pd_w;
  wire wr_vconn_w  = reg_wr_en & hit_vconn_w;
  wire wr_cc1_w    = reg_wr_en & hit_cc1_w;
  wire wr_cc2_w    = reg_wr_en & hit_cc2_w;
  wire wr_vbus_w   = reg_wr_en & hit_vbus_w;

  // supply write with reserved bits forced to zero
  wire [7:0] vbus_wdata_w = reg_wdata & VBUS_FIELD_MASK;

  // read mux, unmapped addresses read zero
  wire [7:0] rd_mux_w =
    hit_pd_w    ? pd_settle_period_q          :
    hit_vconn_w ? vconn_fault_settle_period_q :
    hit_cc1_w   ? cc1_mask_pend_q             :
    hit_cc2_w   ? cc2_mask_pend_q             :
    hit_vbus_w  ? vbus_mask_q                 :
                  8'h00;

  // ---- strap decode from the settled third stage ----
  wire [1:0] cfg_w   = strap_s3_q[1:0];  // configuration select
  wire [1:0] pwr_w   = strap_s3_q[3:2];  // power capability
  wire       agree_w = (strap_s2_q == strap_s3_q); // pins settled
  wire       load_w  = (state_q == ST_STRAP) &&
                       (strap_cnt_q == STRAP_SETTLE_CYCLES) && agree_w;

  // cc default by configuration and current level
  wire [7:0] cc_dflt_w =
    (cfg_w == CFG_UFP)                          ? CC_RST_UFP     :
    (cfg_w == CFG_DFP && pwr_w == PWR_DEFAULT)  ? CC_RST_DFP_DEF :
    (cfg_w == CFG_DFP && pwr_w == PWR_1A5)      ? CC_RST_DFP_1A5 :
    (cfg_w == CFG_DFP)                          ? CC_RST_DFP_3A0 :
                                                  CC_RST_OTHER;

  // supply default by configuration only
  wire [7:0] vbus_dflt_w =
    (cfg_w == CFG_UFP || cfg_w == CFG_DFP) ? VBUS_RST_STANDALONE :
                                             VBUS_RST_OTHER;

  // ---- mask mismatch checks ----
  wire cc_set_restart_w =
    ccvd_mask_restart(cc1_mask_act_q, cc1_mask_pend_q,
                      cc1_threshold_raw, cc1_raw_prev_q) |
    ccvd_mask_restart(cc2_mask_act_q, cc2_mask_pend_q,
                      cc2_threshold_raw, cc2_raw_prev_q);

  wire vbus_set_restart_w =
    ccvd_mask_restart(vbus_mask_q, vbus_wdata_w,
                      supply_threshold_raw & VBUS_FIELD_MASK,
                      vbus_raw_prev_q);

  // cc mask moves to the debouncer only at a scan boundary
  wire cc_apply_w = cc_scan_end && (state_q == ST_RUN);

  // strap state next value
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_STRAP:
      begin
        if (load_w)
        begin
          state_d = ST_RUN;  // defaults captured
        end
      end
      ST_RUN:
      begin
        state_d = ST_RUN;    // stay until reset
      end
      default:
      begin
        state_d = ST_STRAP;
      end
    endcase
  end

  // strap synchroniser, three stages
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
      strap_s3_q <= 4'h0;
    end
    else
    begin
      strap_s1_q <= {power_level_pin1, power_level_pin0, role_config_pin};
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end

  // strap wait counter and state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_cnt_q <= 2'h0;
      state_q     <= ST_STRAP;
    end
    else
    begin
      if (strap_cnt_q != STRAP_SETTLE_CYCLES)
      begin
        strap_cnt_q <= strap_cnt_q + 2'h1;  // saturate at settle count
      end
      state_q <= state_d;
    end
  end

  // settle period registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_settle_period_q          <= PD_SETTLE_RST;
      vconn_fault_settle_period_q <= VCONN_SETTLE_RST;
    end
    else
    begin
      if (wr_pd_w)
      begin
        pd_settle_period_q <= reg_wdata;
      end
      if (wr_vconn_w)
      begin
        vconn_fault_settle_period_q <= reg_wdata;
      end
    end
  end

  // cc masks as written; strap load overrides during capture
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc1_mask_pend_q <= CC_RST_OTHER;
      cc2_mask_pend_q <= CC_RST_OTHER;
    end
    else if (load_w)
    begin
      cc1_mask_pend_q <= cc_dflt_w;
      cc2_mask_pend_q <= cc_dflt_w;
    end
    else
    begin
      if (wr_cc1_w)
      begin
        cc1_mask_pend_q <= reg_wdata;
      end
      if (wr_cc2_w)
      begin
        cc2_mask_pend_q <= reg_wdata;
      end
    end
  end

  // cc masks in use, updated at scan end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc1_mask_act_q <= CC_RST_OTHER;
      cc2_mask_act_q <= CC_RST_OTHER;
      cc_restart_q   <= 1'b0;
    end
    else if (load_w)
    begin
      cc1_mask_act_q <= cc_dflt_w;
      cc2_mask_act_q <= cc_dflt_w;
      cc_restart_q   <= 1'b1;       // start from a clean count
    end
    else
    begin
      if (cc_apply_w)
      begin
        cc1_mask_act_q <= cc1_mask_pend_q;
        cc2_mask_act_q <= cc2_mask_pend_q;
      end
      cc_restart_q <= cc_apply_w && cc_set_restart_w;
    end
  end

  // supply mask, effective at once
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vbus_mask_q    <= VBUS_RST_OTHER;
      vbus_restart_q <= 1'b0;
    end
    else if (load_w)
    begin
      vbus_mask_q    <= vbus_dflt_w;
      vbus_restart_q <= 1'b1;
    end
    else
    begin
      if (wr_vbus_w)
      begin
        vbus_mask_q <= vbus_wdata_w;
      end
      vbus_restart_q <= wr_vbus_w && vbus_set_restart_w;
    end
  end

  // previous raw vectors for the mismatch check
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc1_raw_prev_q  <= 8'h00;
      cc2_raw_prev_q  <= 8'h00;
      vbus_raw_prev_q <= 8'h00;
    end
    else
    begin
      cc1_raw_prev_q  <= cc1_threshold_raw;
      cc2_raw_prev_q  <= cc2_threshold_raw;
      vbus_raw_prev_q <= supply_threshold_raw & VBUS_FIELD_MASK;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q    <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= reg_rd_en;
      if (reg_rd_en)
      begin
        rdata_q <= rd_mux_w;
      end
    end
  end

  // ---- 1 ms time base ----
  ccvd_ms_tick
  #(
    .CYCLES (SETTLE_CYCLES)
  )
  u_tick
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick_ms (tick_ms)
  );

  // one debouncer across both cc pins
  ccvd_settle_filter
  #(
    .WIDTH (16)
  )
  u_cc_filter
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .tick_ms     (tick_ms),
    .period      (pd_settle_period_q),
    .restart     (cc_restart_q),
    .raw         ({cc2_threshold_raw, cc1_threshold_raw}),
    .filter_mask ({cc2_mask_act_q, cc1_mask_act_q}),
    .result      ({cc2_threshold_result, cc1_threshold_result})
  );

  // supply debouncer, shares the pd period
  ccvd_settle_filter
  #(
    .WIDTH (8)
  )
  u_supply_filter
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .tick_ms     (tick_ms),
    .period      (pd_settle_period_q),
    .restart     (vbus_restart_q),
    .raw         (supply_threshold_raw & VBUS_FIELD_MASK),
    .filter_mask (vbus_mask_q),
    .result      (supply_threshold_result)
  );

  // cable overload and back-drive debouncer, always filtered
  ccvd_settle_filter
  #(
    .WIDTH (2)
  )
  u_fault_filter
  (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .tick_ms     (tick_ms),
    .period      (vconn_fault_settle_period_q),
    .restart     (1'b0),
    .raw         ({cc_backdrive_raw, cable_overload_raw}),
    .filter_mask (2'b11),
    .result      ({cc_backdrive_settled, cable_overload_settled})
  );

  // register port outputs
  assign reg_rdata    = rdata_q;
  assign reg_rd_valid = rd_valid_q;
  assign strap_done   = (state_q == ST_RUN);

endmodule : ccvd_debounce_config
`default_nettype wire

// ===== design/ccvd_pkg.sv
// ccvd_pkg: offsets, reset values, strap codes and timing counts
// for the debounce configuration bank and its settle filters.
// assumes a 250 MHz system clock and a 12-bit byte register address.
package ccvd_pkg;

  // register address width and data width
  localparam int          ADDR_W             = 12;
  localparam int          DATA_W             = 8;

  // register byte addresses
  localparam logic [11:0] PD_SETTLE_OFS      = 12'h818;
  localparam logic [11:0] VCONN_SETTLE_OFS   = 12'h819;
  localparam logic [11:0] CC1_MASK_OFS       = 12'h81A;
  localparam logic [11:0] CC2_MASK_OFS       = 12'h81B;
  localparam logic [11:0] VBUS_MASK_OFS      = 12'h81C;

  // period reset values, 1 ms units
  localparam logic [7:0]  PD_SETTLE_RST      = 8'h0A;
  localparam logic [7:0]  VCONN_SETTLE_RST   = 8'h02;

  // supply mask: bits 5:2 thresholds 3..0, bit 0 zero-volt level
  localparam logic [7:0]  VBUS_FIELD_MASK    = 8'h3D;
  localparam int          ZERO_VOLT_BIT      = 0;
  localparam int          SUPPLY_THR0_BIT    = 2;
  localparam int          SUPPLY_THR3_BIT    = 5;

  // cc mask strap defaults
  localparam logic [7:0]  CC_RST_UFP         = 8'h15;
  localparam logic [7:0]  CC_RST_DFP_DEF     = 8'h21;
  localparam logic [7:0]  CC_RST_DFP_1A5     = 8'h22;
  localparam logic [7:0]  CC_RST_DFP_3A0     = 8'h48;
  localparam logic [7:0]  CC_RST_OTHER       = 8'h00;

  // supply mask strap defaults
  localparam logic [7:0]  VBUS_RST_STANDALONE = 8'h0D;
  localparam logic [7:0]  VBUS_RST_OTHER      = 8'h00;

  // configuration-select pin codes
  localparam logic [1:0]  CFG_OTHER          = 2'h0;
  localparam logic [1:0]  CFG_UFP            = 2'h1;
  localparam logic [1:0]  CFG_DFP            = 2'h2;

  // power-capability pin codes {pin1, pin0}; 2'h3 also means 3.0 A
  localparam logic [1:0]  PWR_DEFAULT        = 2'h0;
  localparam logic [1:0]  PWR_1A5            = 2'h1;

  // time base: one settle unit is 1 ms
  localparam int          SETTLE_UNIT_NS     = 1000000;
  localparam int          CLK_PERIOD_NS      = 4;
  localparam int          SETTLE_UNIT_CYCLES = SETTLE_UNIT_NS / CLK_PERIOD_NS;

  // cycles the strap synchroniser needs before its value is trusted
  localparam logic [1:0]  STRAP_SETTLE_CYCLES = 2'h3;

  // strap capture state
  typedef enum logic [0:0]
  {
    ST_STRAP = 1'b0,
    ST_RUN   = 1'b1
  } ccvd_state_type;

  // newly set mask bits with a differing masked raw vector
  function automatic logic ccvd_mask_restart
  (
    input logic [7:0] old_mask,
    input logic [7:0] new_mask,
    input logic [7:0] raw_now,
    input logic [7:0] raw_prev
  );
    logic any_set;
    any_set = |(new_mask & ~old_mask);
    return any_set && ((raw_now & new_mask) != (raw_prev & old_mask));
  endfunction : ccvd_mask_restart

endpackage : ccvd_pkg

// ===== design/ccvd_ms_tick.sv
// ccvd_ms_tick: one-cycle pulse every settle unit of the system clock.
// assumes CYCLES is at least 2.
`timescale 1ns/100ps
`default_nettype none
module ccvd_ms_tick
  import ccvd_pkg::*;
#(
  parameter int unsigned CYCLES = SETTLE_UNIT_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      tick_ms
);

  localparam int CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_q;   // cycles within the current unit
  logic          tick_q;  // registered pulse
  wire           last_w = (cnt_q == CW'(CYCLES - 1));  // unit ends

  // free-running unit counter
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= last_w ? '0 : cnt_q + CW'(1);
      tick_q <= last_w;
    end
  end

  assign tick_ms = tick_q;

endmodule : ccvd_ms_tick
`default_nettype wire

// ===== design/ccvd_settle_filter.sv
// ccvd_settle_filter: debouncer over a vector of threshold results.
// assumes raw comes from logic on clk_sys and tick_ms is a 1-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module ccvd_settle_filter
  import ccvd_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             tick_ms,
  input  wire logic [7:0]       period,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] raw,
  input  wire logic [WIDTH-1:0] filter_mask,
  output logic      [WIDTH-1:0] result
);

  logic [WIDTH-1:0] watch_q;   // masked raw under observation
  logic [WIDTH-1:0] stable_q;  // last accepted masked value
  logic [WIDTH-1:0] result_q;  // output register
  logic [7:0]       cnt_q;     // unit ticks seen without change

  wire [WIDTH-1:0] watched_w = raw & filter_mask;     // filtered bits only
  wire             changed_w = (watched_w != watch_q); // any watched change
  wire             settled_w = (cnt_q >= period);      // period reached
  wire             clear_w   = restart | changed_w;    // count from zero
  // accepted value, or held value while settling; a bit that turns
  // filtered keeps its last shown level instead of a stale one
  wire [WIDTH-1:0] held_w    = (!clear_w && settled_w) ? watch_q : stable_q;

  // settle counter and observed value
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watch_q <= '0;
      cnt_q   <= 8'h00;
    end
    else if (clear_w)
    begin
      watch_q <= watched_w;
      cnt_q   <= 8'h00;
    end
    else if (tick_ms && !settled_w)
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // accept and publish: unfiltered bits follow raw at once
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stable_q <= '0;
      result_q <= '0;
    end
    else
    begin
      stable_q <= (held_w & filter_mask) | (raw & ~filter_mask);
      result_q <= (stable_q & filter_mask) | (raw & ~filter_mask);
    end
  end

  assign result = result_q;

endmodule : ccvd_settle_filter
`default_nettype wire

// ===== tb/ccvd_debounce_assertions.sv
// ccvd_debounce_assertions: port checks on the debounce config bank.
// assumes it is bound to ccvd_debounce_config, one clock clk_sys.
`timescale 1ns/100ps
`default_nettype none
module ccvd_debounce_assertions
  import ccvd_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_UNIT_CYCLES
)
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              reg_wr_en,
  input wire logic              reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              reg_rd_valid,
  input wire logic [1:0]        role_config_pin,
  input wire logic              power_level_pin0,
  input wire logic              power_level_pin1,
  input wire logic              cc_scan_end,
  input wire logic [7:0]        cc1_threshold_raw,
  input wire logic [7:0]        cc2_threshold_raw,
  input wire logic [7:0]        supply_threshold_raw,
  input wire logic              cable_overload_raw,
  input wire logic              cc_backdrive_raw,
  input wire logic [7:0]        cc1_threshold_result,
  input wire logic [7:0]        cc2_threshold_result,
  input wire logic [7:0]        supply_threshold_result,
  input wire logic              cable_overload_settled,
  input wire logic              cc_backdrive_settled,
  input wire logic              strap_done
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // address outside the five mapped bytes
  wire logic unmapped;
  assign unmapped = (reg_addr < PD_SETTLE_OFS) || (reg_addr > VBUS_MASK_OFS);

  a_read_answered: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered next cycle");
  a_no_stray_valid: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read valid without request");
  a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_unmapped_zero: assert property
    (reg_rd_en && unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_vbus_reserved_rd: assert property (reg_rd_en &&
    reg_addr == VBUS_MASK_OFS |=> (reg_rdata & 8'hC2) == 8'h00)
    else $error("supply mask reserved bits read set");
  a_supply_out_bits: assert property
    (strap_done |-> (supply_threshold_result & 8'hC2) == 8'h00)
    else $error("supply result reserved bit set");
  a_strap_done_holds: assert property (strap_done |=> strap_done)
    else $error("strap done dropped");
  a_cable_follows: assert property ($changed(cable_overload_settled)
    |-> cable_overload_settled == $past(cable_overload_raw))
    else $error("cable fault settled to unseen level");
  a_backdrive_follows: assert property ($changed(cc_backdrive_settled)
    |-> cc_backdrive_settled == $past(cc_backdrive_raw))
    else $error("back-drive settled to unseen level");

  // main scenarios reached
  c_read: cover property (reg_rd_en ##1 reg_rd_valid);
  c_cable: cover property ($rose(cable_overload_settled));
  c_scan: cover property (cc_scan_end ##1 !cc_scan_end);
endmodule : ccvd_debounce_assertions

bind ccvd_debounce_config ccvd_debounce_assertions
  #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk
(
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .role_config_pin(role_config_pin), .power_level_pin0(power_level_pin0),
  .power_level_pin1(power_level_pin1), .cc_scan_end(cc_scan_end),
  .cc1_threshold_raw(cc1_threshold_raw),
  .cc2_threshold_raw(cc2_threshold_raw),
  .supply_threshold_raw(supply_threshold_raw),
  .cable_overload_raw(cable_overload_raw),
  .cc_backdrive_raw(cc_backdrive_raw),
  .cc1_threshold_result(cc1_threshold_result),
  .cc2_threshold_result(cc2_threshold_result),
  .supply_threshold_result(supply_threshold_result),
  .cable_overload_settled(cable_overload_settled),
  .cc_backdrive_settled(cc_backdrive_settled), .strap_done(strap_done)
);
`default_nettype wire

// ===== tb/tb_cc_vbus_debounce_config.sv
// tb_cc_vbus_debounce_config: register and debounce tests of the bank.
// assumes an 8-cycle settle unit stands in for 1 ms.
`timescale 1ns/100ps
`default_nettype none
module tb_cc_vbus_debounce_config
  import ccvd_pkg::*;
;
  logic       clk_sys, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cc1_raw, cc2_raw, sup_raw;
  logic [7:0] cc1_res, cc2_res, sup_res;
  logic [1:0] role_config_pin;
  logic       power_level_pin0, power_level_pin1, cc_scan_end;
  logic       cab_raw, bd_raw, cab_set, bd_set, strap_done;
  int         mismatches, num_checks, cycles, n;
  // strap table: role, power, cc default, supply default
  localparam logic [1:0] ROLE_T [6] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0};
  localparam logic [1:0] PW_T [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  localparam logic [7:0] CC_T [6] = '{8'h15, 8'h21, 8'h22, 8'h48, 8'h48,
                                      8'h00};
  localparam logic [7:0] VB_T [6] = '{8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0D,
                                      8'h00};

  ccvd_debounce_config #(.SETTLE_CYCLES(8)) u_dut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .role_config_pin(role_config_pin), .power_level_pin0(power_level_pin0),
    .power_level_pin1(power_level_pin1), .cc_scan_end(cc_scan_end),
    .cc1_threshold_raw(cc1_raw), .cc2_threshold_raw(cc2_raw),
    .supply_threshold_raw(sup_raw), .cable_overload_raw(cab_raw),
    .cc_backdrive_raw(bd_raw), .cc1_threshold_result(cc1_res),
    .cc2_threshold_result(cc2_res), .supply_threshold_result(sup_res),
    .cable_overload_settled(cab_set), .cc_backdrive_settled(bd_set),
    .strap_done(strap_done)
  );

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // k edges, then drive just after the last one
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    cyc(1);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    cyc(1);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    cyc(1);
    reg_rd_en = 1'b0;
    chk({7'h00, reg_rd_valid}, 8'h01);
    chk(reg_rdata, exp);
  endtask : rd

  // reset with given straps, wait for defaults to load
  task automatic do_reset(input logic [1:0] role, input logic [1:0] pw);
    rst_n = 1'b0;
    role_config_pin = role;
    {power_level_pin1, power_level_pin0} = pw;
    cyc(6);
    rst_n = 1'b1;
    n = 0;
    while (strap_done !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk({7'h00, strap_done}, 8'h01);
  endtask : do_reset

  task automatic scan;
    cc_scan_end = 1'b1;
    cyc(1);
    cc_scan_end = 1'b0;
  endtask : scan

  initial
  begin
    {clk_sys, reg_wr_en, reg_rd_en, cc_scan_end, cab_raw, bd_raw} = '0;
    {reg_addr, reg_wdata, cc1_raw, cc2_raw, sup_raw} = '0;
    {mismatches, num_checks, cycles} = '0;
    // strap dependent defaults
    for (int i = 0; i < 6; i++)
    begin
      do_reset(ROLE_T[i], PW_T[i]);
      rd(PD_SETTLE_OFS, 8'h0A);
      rd(VCONN_SETTLE_OFS, 8'h02);
      rd(CC1_MASK_OFS, CC_T[i]);
      rd(CC2_MASK_OFS, CC_T[i]);
      rd(VBUS_MASK_OFS, VB_T[i]);
    end
    $display("test reset defaults done");
    // read/write, reserved and unmapped places
    wr(PD_SETTLE_OFS, 8'h55);
    rd(PD_SETTLE_OFS, 8'h55);
    wr(VCONN_SETTLE_OFS, 8'hAA);
    rd(VCONN_SETTLE_OFS, 8'hAA);
    wr(CC1_MASK_OFS, 8'h3C);
    rd(CC1_MASK_OFS, 8'h3C);
    wr(CC2_MASK_OFS, 8'hC3);
    rd(CC2_MASK_OFS, 8'hC3);
    wr(VBUS_MASK_OFS, 8'hFF);
    rd(VBUS_MASK_OFS, 8'h3D);
    rd(12'h817, 8'h00);
    rd(12'h81D, 8'h00);
    $display("test register access done");
    // all thresholds unfiltered: results follow one cycle later
    wr(PD_SETTLE_OFS, 8'h04);
    wr(VCONN_SETTLE_OFS, 8'h03);
    wr(CC1_MASK_OFS, 8'h00);
    wr(CC2_MASK_OFS, 8'h00);
    wr(VBUS_MASK_OFS, 8'h00);
    scan();
    cc1_raw = 8'hA4;
    cc2_raw = 8'h5A;
    sup_raw = 8'hFF;
    cyc(1);
    chk(cc1_res, 8'hA4);
    chk(cc2_res, 8'h5A);
    chk(sup_res, 8'h3D);
    $display("test unfiltered done");
    // cc mask pending until scan end
    wr(CC1_MASK_OFS, 8'h01);
    wr(CC2_MASK_OFS, 8'h01);
    wr(VBUS_MASK_OFS, 8'h04);
    cc1_raw = 8'hA5;
    cyc(1);
    chk(cc1_res, 8'hA5);
    scan();
    cyc(3);
    cc1_raw = 8'hA4;
    sup_raw = 8'hFB;
    cab_raw = 1'b1;
    bd_raw  = 1'b1;
    cyc(5);
    chk(cc1_res, 8'hA5);
    chk(sup_res, 8'h3D);
    chk({7'h00, cab_set}, 8'h00);
    chk({7'h00, bd_set}, 8'h00);
    // cc2 chatter keeps the shared debouncer restarting
    repeat (10)
    begin
      cc2_raw = cc2_raw ^ 8'h01;
      cyc(4);
    end
    chk(cc1_res, 8'hA5);
    n = 0;
    while (cc1_res !== 8'hA4 && n < 80)
    begin
      cyc(1);
      n++;
    end
    chk(cc1_res, 8'hA4);
    chk(cc2_res, 8'h5A);
    chk(sup_res, 8'h39);
    chk({7'h00, cab_set}, 8'h01);
    chk({7'h00, bd_set}, 8'h01);
    $display("test filtered done");
    complete_run();
  end
endmodule : tb_cc_vbus_debounce_config
`default_nettype wire
